//--- ce_low_qualifier.sv
// Chip enable low-level qualifier on the always-on slow tick
`timescale 1ns/100ps
module ce_low_qualifier (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Slow tick and pin
  input wire logic lf_tick,
  input wire logic chip_enable,
  // Result
  output logic ce_low_qualified
);
  logic [power_mode_pkg::lf_count_width-1:0] low_count;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      low_count <= '0;
    end else if (chip_enable) begin
      low_count <= '0;
    end else if (lf_tick && low_count != power_mode_pkg::ce_low_lf_ticks) begin
      low_count <= low_count + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ce_low_qualified <= 1'b0;
    end else begin
      ce_low_qualified <= !chip_enable && low_count == power_mode_pkg::ce_low_lf_ticks;
    end
  end
endmodule : ce_low_qualifier

//--- host_model.sv
// Host model driving chip enable, select and handshake pins
`timescale 1ns/100ps
module host_model (
  // Clock
  input wire logic clock,
  // Host pins
  output logic chip_enable,
  output logic spi_select_n,
  output logic host_rx_handshake_pin,
  output logic host_data_ready_irq_pin
);
  initial begin
    chip_enable = 1'b1;
    spi_select_n = 1'b1;
    host_rx_handshake_pin = 1'b0;
    host_data_ready_irq_pin = 1'b0;
  end
  task automatic set_ce(input logic v);
    @(negedge clock) chip_enable = v;
  endtask : set_ce
  task automatic select_fall();
    @(negedge clock) spi_select_n = 1'b0;
    repeat (4) @(negedge clock);
    spi_select_n = 1'b1;
  endtask : select_fall
  task automatic toggle_gpio(input bit pin5);
    @(negedge clock);
    if (pin5) host_data_ready_irq_pin = ~host_data_ready_irq_pin;
    else host_rx_handshake_pin = ~host_rx_handshake_pin;
  endtask : toggle_gpio
endmodule : host_model

//--- power_mode_checker.sv
// Port assertions for the power-mode controller
`timescale 1ns/100ps
module power_mode_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Pins and events
  input wire logic chip_enable,
  input wire logic spi_select_n,
  input wire logic host_rx_handshake_pin,
  input wire logic host_data_ready_irq_pin,
  input wire logic wakeup_timer_expired,
  input wire logic temperature_event,
  input wire logic command_valid,
  input wire power_mode_pkg::command_type command,
  // Status
  input wire power_mode_pkg::mode_type mode,
  input wire logic digital_core_supply,
  input wire logic memory_supply,
  input wire logic rf_enable
);
  wire act = mode == power_mode_pkg::mode_active;
  wire ret = mode == power_mode_pkg::mode_deep_retention;
  wire off = mode == power_mode_pkg::mode_hard_off;
  wire boot = mode == power_mode_pkg::mode_autoload;
  logic [12:0] boot_count;
  logic [10:0] low_count;
  always_ff @(posedge clock) begin
    if (!rst_n || !boot) boot_count <= 13'h0000;
    else if (boot_count != 13'h1FFF) boot_count <= boot_count + 13'h0001;
  end
  // Saturating count of consecutive low chip enable cycles
  always_ff @(posedge clock) begin
    if (!rst_n || chip_enable) low_count <= 11'h000;
    else if (low_count != 11'h7FF) low_count <= low_count + 11'h001;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_cmd_ret; act && command_valid && command == power_mode_pkg::cmd_deep_retention |=> ret; endproperty
  a_cmd_ret: assert property (p_cmd_ret) else $error("Retention not entered");
  property p_ret_supply; $rose(ret) |-> ##[1:999] (!digital_core_supply || !ret); endproperty
  a_ret_supply: assert property (p_ret_supply) else $error("Core supply late in retention");
  property p_ce_supply; $fell(chip_enable) && act |-> ##[1:999] (!digital_core_supply || chip_enable); endproperty
  a_ce_supply: assert property (p_ce_supply) else $error("Core supply late after enable low");
  property p_ce_off; low_count == 11'h352 |-> off; endproperty
  a_ce_off: assert property (p_ce_off) else $error("Long enable low not hard off");
  property p_stay_off; off && !chip_enable |=> off; endproperty
  a_stay_off: assert property (p_stay_off) else $error("Hard off left with enable low");
  property p_wake; ret && (wakeup_timer_expired || temperature_event || $fell(spi_select_n)
    || $changed(host_rx_handshake_pin) || $changed(host_data_ready_irq_pin)) |-> ##[1:2] boot; endproperty
  a_wake: assert property (p_wake) else $error("Wake event ignored");
  property p_boot_min; boot && boot_count < 13'h0E10 |=> !act; endproperty
  a_boot_min: assert property (p_boot_min) else $error("Wakeup too short");
  property p_rf_off; !act |-> !rf_enable; endproperty
  a_rf_off: assert property (p_rf_off) else $error("Radio on outside active");
  property p_mem; ret |-> memory_supply; endproperty
  a_mem: assert property (p_mem) else $error("Memory unpowered in retention");
endmodule : power_mode_checker
bind uwb_power_mode_controller power_mode_checker i_chk (.clock, .rst_n, .chip_enable, .spi_select_n,
  .host_rx_handshake_pin, .host_data_ready_irq_pin, .wakeup_timer_expired, .temperature_event,
  .command_valid, .command, .mode, .digital_core_supply, .memory_supply, .rf_enable);

//--- power_mode_pkg.sv
// Constants and types for the power-mode controller
package power_mode_pkg;
  localparam int unsigned clock_hz = 10_000_000;
  localparam int unsigned clock_period_ns = 100;
  // Chip enable low qualification time, 80 us
  localparam int unsigned ce_low_time_us = 80;
  localparam int unsigned ce_low_cycles = (ce_low_time_us * 1000 + clock_period_ns - 1) / clock_period_ns + 1;
  // Longest time to finish power-down entry, 100 us
  localparam int unsigned pd_entry_time_us = 100;
  localparam int unsigned pd_entry_cycles = (pd_entry_time_us * 1000) / clock_period_ns;
  // Power-down core supply off delay inside the entry window
  // Short enough that the enable-low path also finishes within the entry window
  localparam int unsigned pd_settle_cycles = (pd_entry_cycles - ce_low_cycles) / 2;
  // Wakeup times
  localparam int unsigned wake_retention_time_us = 370;
  localparam int unsigned wake_retention_cycles = (wake_retention_time_us * 1000) / clock_period_ns;
  localparam int unsigned wake_hard_off_time_us = 380;
  localparam int unsigned wake_hard_off_cycles = (wake_hard_off_time_us * 1000) / clock_period_ns;
  // Supply to chip enable window, 50 us
  localparam int unsigned ce_power_window_us = 50;
  localparam int unsigned ce_power_window_cycles = (ce_power_window_us * 1000) / clock_period_ns;
  localparam int unsigned count_width = 13;
  localparam int unsigned lf_count_width = 8;
  // Always-on low-frequency tick divider and its qualification count
  localparam logic [7:0] lf_divide = 8'h0A;
  // Rounded up so that a low pulse of exactly the limit never qualifies
  localparam logic [lf_count_width-1:0] ce_low_lf_ticks = lf_count_width'((ce_low_cycles + lf_divide - 1) / lf_divide);

  typedef enum logic [2:0] {
    cmd_none,
    cmd_hard_off,
    cmd_deep_retention,
    cmd_sleep,
    cmd_wake,
    cmd_tx,
    cmd_rx,
    cmd_dual_rx
  } command_type;

  typedef enum logic [2:0] {
    sub_idle,
    sub_tx,
    sub_rx,
    sub_dual_rx
  } substate_type;

  typedef enum logic [2:0] {
    mode_hard_off,
    mode_deep_retention,
    mode_sleep,
    mode_autoload,
    mode_active
  } mode_type;
endpackage : power_mode_pkg

//--- tb.sv
// Self-checking bench for the power-mode controller
`timescale 1ns/100ps
module tb;
  logic clock, rst_n, wakeup_timer_expired, temperature_event, command_valid, autoload_done;
  logic chip_enable, spi_select_n, host_rx_handshake_pin, host_data_ready_irq_pin;
  logic digital_core_supply, memory_supply, rf_enable, firmware_reload, powerdown_done;
  logic [7:0] sleep_keep_config, sleep_keep_active;
  power_mode_pkg::command_type command;
  power_mode_pkg::mode_type mode;
  power_mode_pkg::substate_type substate;
  int n_mismatch, tests_run;
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  host_model i_host (.clock, .chip_enable, .spi_select_n, .host_rx_handshake_pin, .host_data_ready_irq_pin);
  uwb_power_mode_controller i_dut (.clock, .rst_n, .chip_enable, .spi_select_n, .host_rx_handshake_pin,
    .host_data_ready_irq_pin, .wakeup_timer_expired, .temperature_event, .command_valid, .command,
    .sleep_keep_config, .autoload_done, .mode, .substate, .digital_core_supply, .memory_supply, .rf_enable,
    .firmware_reload, .sleep_keep_active, .powerdown_done);
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic chk_mode(input power_mode_pkg::mode_type m);
    check("mode", 8'(mode), 8'(m));
  endtask : chk_mode
  task automatic send(input power_mode_pkg::command_type c);
    @(negedge clock);
    command_valid = 1'b1;
    command = c;
    @(negedge clock);
    command_valid = 1'b0;
  endtask : send
  // Bounded wait for a mode, n returns the cycles spent
  task automatic wait_mode(input power_mode_pkg::mode_type m, input int lim, output int n);
    n = 0;
    while (mode !== m) begin
      if (n == lim) begin
        n_mismatch++;
        $display("ERROR wait mode expected %h seen %h", m, mode);
        stop_test();
      end
      @(negedge clock);
      n++;
    end
  endtask : wait_mode
  task automatic t_boot();
    int n;
    check("core supply", 8'(digital_core_supply), 8'h01);
    repeat (4000) @(negedge clock);
    chk_mode(power_mode_pkg::mode_autoload);
    check("rf", 8'(rf_enable), 8'h00);
    check("reload", 8'(firmware_reload), 8'h01);
    autoload_done = 1'b1;
    wait_mode(power_mode_pkg::mode_active, 4, n);
    chk_mode(power_mode_pkg::mode_active);
    $display("boot test done");
  endtask : t_boot
  task automatic t_ret(input int ev);
    int n;
    send(power_mode_pkg::cmd_deep_retention);
    chk_mode(power_mode_pkg::mode_deep_retention);
    repeat (998) @(negedge clock);
    check("core supply", 8'(digital_core_supply), 8'h00);
    check("memory", 8'(memory_supply), 8'h01);
    check("pd done", 8'(powerdown_done), 8'h01);
    @(negedge clock);
    case (ev)
      0: wakeup_timer_expired = 1'b1;
      1: temperature_event = 1'b1;
      2: i_host.select_fall();
      default: i_host.toggle_gpio(ev == 4);
    endcase
    @(negedge clock);
    wakeup_timer_expired = 1'b0;
    temperature_event = 1'b0;
    wait_mode(power_mode_pkg::mode_active, 4500, n);
    check("wake time", 8'(n > 3590 && n < 3800), 8'h01);
    $display("retention test %0d done", ev);
  endtask : t_ret
  task automatic t_sub();
    power_mode_pkg::command_type c[3] = '{power_mode_pkg::cmd_tx, power_mode_pkg::cmd_rx, power_mode_pkg::cmd_dual_rx};
    power_mode_pkg::substate_type s[3] = '{power_mode_pkg::sub_tx, power_mode_pkg::sub_rx, power_mode_pkg::sub_dual_rx};
    for (int i = 0; i < 3; i++) begin
      send(c[i]);
      check("substate", 8'(substate), 8'(s[i]));
      @(negedge clock);
      check("rf", 8'(rf_enable), 8'h01);
    end
    $display("substate test done");
  endtask : t_sub
  task automatic t_ce();
    int n;
    i_host.set_ce(1'b0);
    repeat (400) @(negedge clock);
    i_host.set_ce(1'b1);
    chk_mode(power_mode_pkg::mode_active);
    i_host.set_ce(1'b0);
    repeat (999) @(negedge clock);
    chk_mode(power_mode_pkg::mode_hard_off);
    check("core supply", 8'(digital_core_supply), 8'h00);
    check("memory", 8'(memory_supply), 8'h00);
    i_host.set_ce(1'b1);
    wait_mode(power_mode_pkg::mode_active, 4500, n);
    check("wake time", 8'(n > 3690 && n < 3900), 8'h01);
    send(power_mode_pkg::cmd_hard_off);
    chk_mode(power_mode_pkg::mode_hard_off);
    i_host.set_ce(1'b0);
    repeat (600) @(negedge clock);
    chk_mode(power_mode_pkg::mode_hard_off);
    autoload_done = 1'b0;
    i_host.set_ce(1'b1);
    repeat (3900) @(negedge clock);
    chk_mode(power_mode_pkg::mode_autoload);
    check("reload", 8'(firmware_reload), 8'h01);
    autoload_done = 1'b1;
    wait_mode(power_mode_pkg::mode_active, 4, n);
    chk_mode(power_mode_pkg::mode_active);
    $display("enable test done");
  endtask : t_ce
  task automatic t_sleep();
    sleep_keep_config = 8'hA5;
    send(power_mode_pkg::cmd_sleep);
    chk_mode(power_mode_pkg::mode_sleep);
    check("keep", sleep_keep_active, 8'hA5);
    check("rf", 8'(rf_enable), 8'h00);
    send(power_mode_pkg::cmd_wake);
    chk_mode(power_mode_pkg::mode_active);
    $display("sleep test done");
  endtask : t_sleep
  task automatic t_late_ce();
    int n;
    @(negedge clock);
    rst_n = 1'b0;
    i_host.set_ce(1'b0);
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    repeat (700) @(negedge clock);
    chk_mode(power_mode_pkg::mode_hard_off);
    check("core supply", 8'(digital_core_supply), 8'h00);
    i_host.set_ce(1'b1);
    wait_mode(power_mode_pkg::mode_active, 4500, n);
    check("wake time", 8'(n > 3690 && n < 3900), 8'h01);
    $display("late enable test done");
  endtask : t_late_ce
  initial begin
    rst_n = 1'b0;
    wakeup_timer_expired = 1'b0;
    temperature_event = 1'b0;
    command_valid = 1'b0;
    command = power_mode_pkg::cmd_none;
    sleep_keep_config = 8'h00;
    autoload_done = 1'b0;
    n_mismatch = 0;
    tests_run = 0;
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    t_boot();
    for (int e = 0; e < 5; e++) t_ret(e);
    t_sub();
    t_ce();
    t_sleep();
    t_late_ce();
    stop_test();
  end
endmodule : tb

//--- uwb_power_mode_controller.sv
// Power-mode state controller for the transceiver
// Notes on behaviour
// - CE low over 80us or command: hard off
// - Hard off left only by CE high
// - Hard off entry done within 100us
// - Retention entry by command within 100us
// - Timer, temperature, select fall, GPIO wake retention
// - Active entered once boot completes
// - Retention wakeup takes about 370us
// - Hard off wakeup takes about 380us
// - Active substates idle, tx, rx, dual
// - Sleep keeps configured parts; RF off
// - Retention keeps memory; RF off; reload
// - Autoload loads configuration before active
// - CE within 50us of supplies
`timescale 1ns/100ps
module uwb_power_mode_controller (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Host pins
  input wire logic chip_enable,
  input wire logic spi_select_n,
  input wire logic host_rx_handshake_pin,
  input wire logic host_data_ready_irq_pin,
  // Wake events
  input wire logic wakeup_timer_expired,
  input wire logic temperature_event,
  // Firmware command
  input wire logic command_valid,
  input wire power_mode_pkg::command_type command,
  input wire logic [7:0] sleep_keep_config,
  input wire logic autoload_done,
  // Status and controls
  output power_mode_pkg::mode_type mode,
  output power_mode_pkg::substate_type substate,
  output logic digital_core_supply,
  output logic memory_supply,
  output logic rf_enable,
  output logic firmware_reload,
  output logic [7:0] sleep_keep_active,
  output logic powerdown_done
);
  logic lf_tick;
  logic [7:0] lf_div;
  logic ce_low_qualified;
  logic select_prev;
  logic gpio3_prev;
  logic gpio5_prev;
  logic wake_event;
  logic supply_window_open;
  logic [power_mode_pkg::count_width-1:0] window_count;
  logic [power_mode_pkg::count_width-1:0] pd_count;
  logic [power_mode_pkg::count_width-1:0] wake_count;
  logic [power_mode_pkg::count_width-1:0] wake_target;
  logic booting;
  logic pd_pending;
  logic leave_active;

  // Always-on slow tick
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lf_div <= 8'h00;
      lf_tick <= 1'b0;
    end else if (lf_div == power_mode_pkg::lf_divide - 8'h01) begin
      lf_div <= 8'h00;
      lf_tick <= 1'b1;
    end else begin
      lf_div <= lf_div + 8'h01;
      lf_tick <= 1'b0;
    end
  end

  ce_low_qualifier u_ce_low_qualifier (
    .clock(clock),
    .rst_n(rst_n),
    .lf_tick(lf_tick),
    .chip_enable(chip_enable),
    .ce_low_qualified(ce_low_qualified)
  );

  // Edge history for wake sources
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      select_prev <= 1'b1;
      gpio3_prev <= 1'b0;
      gpio5_prev <= 1'b0;
    end else begin
      select_prev <= spi_select_n;
      gpio3_prev <= host_rx_handshake_pin;
      gpio5_prev <= host_data_ready_irq_pin;
    end
  end

  assign wake_event = wakeup_timer_expired || temperature_event || (select_prev && !spi_select_n)
    || (gpio3_prev != host_rx_handshake_pin) || (gpio5_prev != host_data_ready_irq_pin);

  assign leave_active = ce_low_qualified || (command_valid && (command == power_mode_pkg::cmd_hard_off
    || command == power_mode_pkg::cmd_deep_retention || command == power_mode_pkg::cmd_sleep));

  // supply to CE window after reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      window_count <= '0;
      supply_window_open <= 1'b1;
    end else if (supply_window_open) begin
      if (chip_enable) begin
        supply_window_open <= 1'b0;
      end else if (window_count == power_mode_pkg::count_width'(power_mode_pkg::ce_power_window_cycles)) begin
        supply_window_open <= 1'b0;
      end else begin
        window_count <= window_count + 1'b1;
      end
    end
  end

  // Main mode sequencing
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mode <= power_mode_pkg::mode_autoload;
      booting <= 1'b1;
      wake_count <= '0;
      wake_target <= power_mode_pkg::count_width'(power_mode_pkg::wake_hard_off_cycles);
      pd_pending <= 1'b0;
      pd_count <= '0;
    end else begin
      if (pd_pending && pd_count != power_mode_pkg::count_width'(power_mode_pkg::pd_settle_cycles)) begin
        pd_count <= pd_count + 1'b1;
      end
      case (mode)
        power_mode_pkg::mode_hard_off: begin
          if (chip_enable && pd_count == power_mode_pkg::count_width'(power_mode_pkg::pd_settle_cycles)) begin
            mode <= power_mode_pkg::mode_autoload;
            booting <= 1'b1;
            wake_count <= '0;
            pd_pending <= 1'b0;
            wake_target <= power_mode_pkg::count_width'(power_mode_pkg::wake_hard_off_cycles);
          end
        end
        power_mode_pkg::mode_deep_retention: begin
          if (ce_low_qualified) begin
            mode <= power_mode_pkg::mode_hard_off;
            pd_count <= '0;
            pd_pending <= 1'b1;
          end else if (wake_event) begin
            mode <= power_mode_pkg::mode_autoload;
            booting <= 1'b1;
            wake_count <= '0;
            pd_pending <= 1'b0;
            wake_target <= power_mode_pkg::count_width'(power_mode_pkg::wake_retention_cycles);
          end
        end
        power_mode_pkg::mode_autoload: begin
          if (ce_low_qualified || (supply_window_open == 1'b0 && !chip_enable && booting
              && window_count == power_mode_pkg::count_width'(power_mode_pkg::ce_power_window_cycles))) begin
            mode <= power_mode_pkg::mode_hard_off;
            pd_count <= '0;
            pd_pending <= 1'b1;
          end else if (wake_count != wake_target) begin
            wake_count <= wake_count + 1'b1;
          end else if (autoload_done) begin
            mode <= power_mode_pkg::mode_active;
            booting <= 1'b0;
          end
        end
        power_mode_pkg::mode_sleep: begin
          if (ce_low_qualified) begin
            mode <= power_mode_pkg::mode_hard_off;
            pd_count <= '0;
            pd_pending <= 1'b1;
          end else if (wake_event || (command_valid && command == power_mode_pkg::cmd_wake)) begin
            mode <= power_mode_pkg::mode_active;
          end
        end
        default: begin
          if (ce_low_qualified || (command_valid && command == power_mode_pkg::cmd_hard_off)) begin
            mode <= power_mode_pkg::mode_hard_off;
            pd_count <= '0;
            pd_pending <= 1'b1;
          end else if (command_valid && command == power_mode_pkg::cmd_deep_retention) begin
            mode <= power_mode_pkg::mode_deep_retention;
            pd_count <= '0;
            pd_pending <= 1'b1;
          end else if (command_valid && command == power_mode_pkg::cmd_sleep) begin
            mode <= power_mode_pkg::mode_sleep;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      substate <= power_mode_pkg::sub_idle;
    end else if (mode != power_mode_pkg::mode_active) begin
      substate <= power_mode_pkg::sub_idle;
    end else if (command_valid) begin
      case (command)
        power_mode_pkg::cmd_tx: substate <= power_mode_pkg::sub_tx;
        power_mode_pkg::cmd_rx: substate <= power_mode_pkg::sub_rx;
        power_mode_pkg::cmd_dual_rx: substate <= power_mode_pkg::sub_dual_rx;
        power_mode_pkg::cmd_wake: substate <= power_mode_pkg::sub_idle;
        default: substate <= substate;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sleep_keep_active <= 8'h00;
    end else if (command_valid && command == power_mode_pkg::cmd_sleep && mode == power_mode_pkg::mode_active) begin
      sleep_keep_active <= sleep_keep_config;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      digital_core_supply <= 1'b1;
      memory_supply <= 1'b1;
      rf_enable <= 1'b0;
      firmware_reload <= 1'b0;
      powerdown_done <= 1'b0;
    end else begin
      rf_enable <= mode == power_mode_pkg::mode_active && !leave_active && substate != power_mode_pkg::sub_idle;
      firmware_reload <= mode == power_mode_pkg::mode_autoload;
      memory_supply <= mode != power_mode_pkg::mode_hard_off;
      powerdown_done <= pd_pending && pd_count == power_mode_pkg::count_width'(power_mode_pkg::pd_settle_cycles);
      if (pd_pending && pd_count == power_mode_pkg::count_width'(power_mode_pkg::pd_settle_cycles)) begin
        digital_core_supply <= 1'b0;
      end else if (mode == power_mode_pkg::mode_autoload || mode == power_mode_pkg::mode_active
          || mode == power_mode_pkg::mode_sleep) begin
        digital_core_supply <= 1'b1;
      end
    end
  end
endmodule : uwb_power_mode_controller
